/* File: rtl/fcss_defines.vh */
// Shared constants for the flash command and status sequencer
`ifndef FCSS_DEFINES_VH
`define FCSS_DEFINES_VH

// Clock and times
`define FCSS_CLK_NS 40
`define FCSS_ERTO_NS 120000
`define FCSS_PWAIT_NS 100000
`define FCSS_PROG_NS 10000
`define FCSS_ERTO_CYC ((`FCSS_ERTO_NS) / (`FCSS_CLK_NS))
`define FCSS_PWAIT_CYC ((`FCSS_PWAIT_NS) / (`FCSS_CLK_NS))
`define FCSS_PROG_CYC ((`FCSS_PROG_NS + `FCSS_CLK_NS - 1) / (`FCSS_CLK_NS))
`define FCSS_TMR_W 12

// Command data codes
`define FCSS_UNLK1 8'haa
`define FCSS_UNLK2 8'h55
`define FCSS_PROG 8'ha0
`define FCSS_ERASE 8'h80
`define FCSS_SECER 8'h30
`define FCSS_BULK 8'h10
`define FCSS_BYPASS 8'h20
`define FCSS_PROTRD 8'h90
`define FCSS_BYEXIT 8'h00
`define FCSS_RESET 8'hf0

// Command addresses, low twelve bits only; protection read address, low two bits
`define FCSS_ADDR1 12'h555
`define FCSS_ADDR2 12'haaa
`define FCSS_PROT_ADDR 2'h2

// Status bit positions and data values
`define FCSS_BIT_POLL 7
`define FCSS_BIT_TOG 6
`define FCSS_BIT_ERR 5
`define FCSS_BIT_ERTO 3
`define FCSS_ERASED 8'hff

// Array geometry
`define FCSS_PA_W 17
`define FCSS_SA_W 15
`define FCSS_POFF_W 14
`define FCSS_SOFF_W 13

`endif

/* File: rtl/fcss_mem.v */
// Byte array with one write port and a registered read port
`timescale 1ns/1ps
module fcss_mem #(
  parameter AW = 17
) (
  // Clock and enable
  input wire clk_in,
  input wire ce_in,
  // Write port
  input wire we_in,
  input wire [AW-1:0] waddr_in,
  input wire [7:0] wdata_in,
  // Read port
  input wire [AW-1:0] raddr_in,
  output reg [7:0] rdata_out
);

  reg [7:0] mem [0:(1<<AW)-1];

  // Array contents are not reset, as a real array keeps them
  always @(posedge clk_in)
  begin
    if (ce_in)
    begin
      if (we_in)
        mem[waddr_in] <= wdata_in;
      rdata_out <= mem[raddr_in];
    end
  end

endmodule // fcss_mem

/* File: rtl/fcss_sequencer.v */
// Command decoder, embedded program/erase and status read path for both arrays
`timescale 1ns/1ps
`include "fcss_defines.vh"
// Summary of operation
// - Plain reads return array bytes without any command cycles.
// - During embedded operations reads of the operating bank return status; repeated reads are harmless.
// - Polling bit reads inverted programmed bit until programming completes.
// - Flags valid after fourth program or sixth erase write; host polls target.
// - Polling bit reads zero during erase, one afterwards.
// - Program to a protected sector is ignored.
// - All-protected erase: polling and toggle bits zero, time-out bit one, for 100 us, no erase.
// - Toggle bit inverts on each status read while an operation runs, except in the all-protected erase wait.
// - Error bit zero normally, one on program failure.
// - Error bit set on a zero-to-one program attempt, the only program failure.
// - Failed sector avoided by host; error clears only by reset command.
// - Erase time-out bit zero for 120 us, then one, or on added sector.
// - Status byte: polling, toggle, error, time-out on bits 7, 6, 5, 3.
// - Erase sets bytes to ones; program only clears bits, per byte.
// - Completion seen by polling bit, toggle bit or ready/busy pin.
// - Two unlock writes then 20h enter fast-program mode.
// - Fast program is A0h then address and data, no unlock cycles.
// - In fast-program mode only fast program and exit are accepted.
// - Writes 90h then 00h leave fast-program mode to read mode.
// - Commands start with AAh at x555h then 55h at xAAAh.
// - Command decode looks at address bits 11 to 0 only.
// - Primary selects steer commands to primary, secondary selects to secondary unless a primary select is also active.
// - Reset command returns to read mode after protection read or error.
module fcss_sequencer (
  // Clock, reset, enable
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  // Core bus
  input wire rd_strobe_in,
  input wire wr_strobe_in,
  input wire [15:0] addr_in,
  input wire [7:0] wdata_in,
  output reg [7:0] rdata_out,
  output reg rdata_valid_out,
  // Sector selects
  input wire [7:0] primary_sector_selects_in,
  input wire [3:0] secondary_sector_selects_in,
  // Sector protection
  input wire [7:0] prot_primary_in,
  input wire [3:0] prot_secondary_in,
  // Status pins
  output wire ready_busy_pin_out,
  output wire bypass_mode_out,
  output wire error_flag_bit_out
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_C1 = 4'h1;
  localparam [3:0] S_C2 = 4'h2;
  localparam [3:0] S_ER1 = 4'h3;
  localparam [3:0] S_ER2 = 4'h4;
  localparam [3:0] S_ER3 = 4'h5;
  localparam [3:0] S_PGM = 4'h6;
  localparam [3:0] S_PCHK = 4'h7;
  localparam [3:0] S_PRUN = 4'h8;
  localparam [3:0] S_ERTO = 4'h9;
  localparam [3:0] S_ERUN = 4'ha;
  localparam [3:0] S_PWAIT = 4'hb;
  localparam [3:0] S_ERR = 4'hc;
  localparam [3:0] S_PROT = 4'hd;
  localparam [3:0] S_BYP = 4'he;
  localparam [3:0] S_BEXIT = 4'hf;
  localparam integer ERTO_INT = `FCSS_ERTO_CYC;
  localparam integer PWAIT_INT = `FCSS_PWAIT_CYC;
  localparam integer PROG_INT = `FCSS_PROG_CYC;
  // All timed windows fit the timer width, so the upper bits cut here are zero
  localparam [`FCSS_TMR_W-1:0] ERTO_CYC = ERTO_INT[`FCSS_TMR_W-1:0];
  localparam [`FCSS_TMR_W-1:0] PWAIT_CYC = PWAIT_INT[`FCSS_TMR_W-1:0];
  localparam [`FCSS_TMR_W-1:0] PROG_CYC = PROG_INT[`FCSS_TMR_W-1:0];

  // Priority encoder, lowest active select wins
  function [2:0] sec_index;
    input [7:0] sel;
    integer i;
    begin
      sec_index = 3'h0;
      for (i = 7; i >= 0; i = i - 1)
        if (sel[i])
          sec_index = i[2:0];
    end
  endfunction

  reg [3:0] state;
  reg in_byp;
  reg op_bank;
  reg [`FCSS_PA_W-1:0] op_addr;
  reg [7:0] op_data;
  reg [7:0] new_byte;
  reg [7:0] er_mask;
  reg [`FCSS_PA_W-1:0] ecnt;
  reg err_flag;
  reg erto_flag;
  reg toggle;
  reg tmr_load;
  reg [`FCSS_TMR_W-1:0] tmr_count;
  reg rd_pend;
  reg rd_bank;
  reg [1:0] rd_low;
  reg [2:0] rd_sec;
  reg [7:0] status;

  wire tmr_done;
  wire [7:0] p_rdata;
  wire [7:0] s_rdata;

  wire p_any = |primary_sector_selects_in;
  wire s_any = |secondary_sector_selects_in;
  wire sel_any = p_any | s_any;
  wire bank = ~p_any;
  wire [2:0] p_sec = sec_index(primary_sector_selects_in);
  wire [2:0] s_sec = sec_index({4'h0, secondary_sector_selects_in});
  wire [2:0] cur_sec = bank ? s_sec : p_sec;
  wire [`FCSS_PA_W-1:0] p_addr = {p_sec, addr_in[`FCSS_POFF_W-1:0]};
  wire [`FCSS_SA_W-1:0] s_addr = {s_sec[1:0], addr_in[`FCSS_SOFF_W-1:0]};
  wire [`FCSS_PA_W-1:0] cur_addr = bank ? {2'h0, s_addr} : p_addr;
  wire [7:0] prot_all = {4'h0, prot_secondary_in};
  wire [7:0] prot_bank = bank ? prot_all : prot_primary_in;
  wire cur_prot = prot_bank[cur_sec];
  wire wr = wr_strobe_in & sel_any;
  wire rd = rd_strobe_in & sel_any;
  wire [11:0] a12 = addr_in[11:0];
  wire at1 = (a12 == `FCSS_ADDR1);
  wire at2 = (a12 == `FCSS_ADDR2);
  wire [7:0] old_byte = op_bank ? s_rdata : p_rdata;
  wire [3:0] ret_state = in_byp ? S_BYP : S_IDLE;
  wire busy = (state == S_PCHK) | (state == S_PRUN) | (state == S_ERTO) |
              (state == S_ERUN) | (state == S_PWAIT) | (state == S_ERR);

  // Erase sweep covers every byte of the bank; secondary skips the unused offset bit
  wire [2:0] e_sec = op_bank ? {1'b0, ecnt[15:14]} : ecnt[16:14];
  wire e_valid = ~op_bank | (~ecnt[16] & ~ecnt[13]);
  wire e_we = (state == S_ERUN) & e_valid & er_mask[e_sec];
  // The timer still reads done in the load cycle, so hold the commit until it has counted
  wire p_we_prog = (state == S_PRUN) & tmr_done & ~tmr_load;
  wire [`FCSS_PA_W-1:0] e_paddr = ecnt;
  wire [`FCSS_SA_W-1:0] e_saddr = {ecnt[15:14], ecnt[`FCSS_SOFF_W-1:0]};
  wire [7:0] mem_wdata = (state == S_ERUN) ? `FCSS_ERASED : new_byte;
  wire p_we = (p_we_prog | e_we) & ~op_bank;
  wire s_we = (p_we_prog | e_we) & op_bank;
  wire [`FCSS_PA_W-1:0] p_waddr = (state == S_ERUN) ? e_paddr : op_addr;
  wire [`FCSS_SA_W-1:0] s_waddr = (state == S_ERUN) ? e_saddr : op_addr[`FCSS_SA_W-1:0];

  fcss_mem #(.AW(`FCSS_PA_W)) u_primary (
    .clk_in(clk_in),
    .ce_in(ce_in),
    .we_in(p_we),
    .waddr_in(p_waddr),
    .wdata_in(mem_wdata),
    .raddr_in(p_addr),
    .rdata_out(p_rdata)
  );

  fcss_mem #(.AW(`FCSS_SA_W)) u_secondary (
    .clk_in(clk_in),
    .ce_in(ce_in),
    .we_in(s_we),
    .waddr_in(s_waddr),
    .wdata_in(mem_wdata),
    .raddr_in(s_addr),
    .rdata_out(s_rdata)
  );

  fcss_timer u_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .load_in(tmr_load),
    .count_in(tmr_count),
    .done_out(tmr_done)
  );

  // Command sequencer
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state <= S_IDLE;
      in_byp <= 1'b0;
      op_bank <= 1'b0;
      op_addr <= {`FCSS_PA_W{1'b0}};
      op_data <= 8'h00;
      new_byte <= 8'h00;
      er_mask <= 8'h00;
      ecnt <= {`FCSS_PA_W{1'b0}};
      err_flag <= 1'b0;
      erto_flag <= 1'b0;
      tmr_load <= 1'b0;
      tmr_count <= {`FCSS_TMR_W{1'b0}};
    end
    else if (ce_in)
    begin
      tmr_load <= 1'b0;
      case (state)
        S_IDLE:
          if (wr && wdata_in == `FCSS_UNLK1 && at1)
            state <= S_C1;
        S_C1:
          if (wr)
            state <= (wdata_in == `FCSS_UNLK2 && at2) ? S_C2 : S_IDLE;
        S_C2:
          if (wr)
          begin
            op_bank <= bank;
            if (at1 && wdata_in == `FCSS_PROG)
              state <= S_PGM;
            else if (at1 && wdata_in == `FCSS_ERASE)
              state <= S_ER1;
            else if (at1 && wdata_in == `FCSS_BYPASS)
            begin
              in_byp <= 1'b1;
              state <= S_BYP;
            end
            else if (at1 && wdata_in == `FCSS_PROTRD)
              state <= S_PROT;
            else
              state <= S_IDLE;
          end
        S_ER1:
          if (wr)
            state <= (wdata_in == `FCSS_UNLK1 && at1) ? S_ER2 : S_IDLE;
        S_ER2:
          if (wr)
            state <= (wdata_in == `FCSS_UNLK2 && at2) ? S_ER3 : S_IDLE;
        S_ER3:
          if (wr)
          begin
            op_bank <= bank;
            erto_flag <= 1'b0;
            if (wdata_in == `FCSS_SECER)
            begin
              er_mask <= cur_prot ? 8'h00 : (8'h01 << cur_sec);
              tmr_count <= ERTO_CYC;
              tmr_load <= 1'b1;
              state <= S_ERTO;
            end
            else if (wdata_in == `FCSS_BULK && at1)
            begin
              er_mask <= ~prot_bank & (bank ? 8'h0f : 8'hff);
              ecnt <= {`FCSS_PA_W{1'b0}};
              erto_flag <= 1'b1;
              tmr_count <= PWAIT_CYC;
              tmr_load <= 1'b1;
              // Nothing erasable: hold polling and toggle low for the wait window instead
              state <= ((~prot_bank & (bank ? 8'h0f : 8'hff)) == 8'h00) ? S_PWAIT : S_ERUN;
            end
            else
              state <= S_IDLE;
          end
        S_PGM:
          if (wr)
          begin
            if (in_byp && wdata_in == `FCSS_PROG)
              state <= S_PGM;
            else if (cur_prot)
              state <= ret_state;
            else
            begin
              op_bank <= bank;
              op_addr <= cur_addr;
              op_data <= wdata_in;
              state <= S_PCHK;
            end
          end
        S_PCHK:
          // Old byte was read on the data write; a 0 to 1 change cannot be programmed
          if ((~old_byte & op_data) != 8'h00)
          begin
            err_flag <= 1'b1;
            state <= S_ERR;
          end
          else
          begin
            new_byte <= old_byte & op_data;
            tmr_count <= PROG_CYC;
            tmr_load <= 1'b1;
            state <= S_PRUN;
          end
        S_PRUN:
          if (tmr_done && !tmr_load)
            state <= ret_state;
        S_ERTO:
          if (wr)
          begin
            if (wdata_in == `FCSS_SECER && bank == op_bank)
            begin
              if (!cur_prot)
                er_mask <= er_mask | (8'h01 << cur_sec);
              erto_flag <= 1'b1;
              tmr_count <= ERTO_CYC;
              tmr_load <= 1'b1;
            end
            else
              state <= S_IDLE;
          end
          else if (tmr_done && !tmr_load)
          begin
            erto_flag <= 1'b1;
            ecnt <= {`FCSS_PA_W{1'b0}};
            tmr_count <= PWAIT_CYC;
            tmr_load <= 1'b1;
            state <= (er_mask == 8'h00) ? S_PWAIT : S_ERUN;
          end
        S_ERUN:
          if (wr && wdata_in == `FCSS_RESET)
            state <= S_IDLE;
          else if (ecnt == {`FCSS_PA_W{1'b1}})
            state <= S_IDLE;
          else
            ecnt <= ecnt + {{(`FCSS_PA_W-1){1'b0}}, 1'b1};
        S_PWAIT:
          if (tmr_done && !tmr_load)
            state <= S_IDLE;
        S_ERR, S_PROT:
          if (wr && wdata_in == `FCSS_RESET)
          begin
            err_flag <= 1'b0;
            in_byp <= 1'b0;
            state <= S_IDLE;
          end
        S_BYP:
          // Anything but the two valid commands is dropped here
          if (wr && wdata_in == `FCSS_PROG)
            state <= S_PGM;
          else if (wr && wdata_in == `FCSS_PROTRD)
            state <= S_BEXIT;
          else
            state <= S_BYP;
        S_BEXIT:
          if (wr)
          begin
            if (wdata_in == `FCSS_BYEXIT)
            begin
              in_byp <= 1'b0;
              state <= S_IDLE;
            end
            else
              state <= S_BYP;
          end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // Status byte; unassigned bits read as zero
  always @*
  begin
    status = 8'h00;
    status[`FCSS_BIT_POLL] = ((state == S_PCHK) | (state == S_PRUN) | (state == S_ERR)) ?
                             ~op_data[7] : 1'b0;
    status[`FCSS_BIT_TOG] = (state == S_PWAIT) ? 1'b0 : toggle;
    status[`FCSS_BIT_ERR] = err_flag;
    status[`FCSS_BIT_ERTO] = erto_flag & (state != S_PCHK) & (state != S_PRUN) & (state != S_ERR);
  end

  // Read path: memory read register, then output register
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      rd_pend <= 1'b0;
      rd_bank <= 1'b0;
      rd_low <= 2'h0;
      rd_sec <= 3'h0;
      toggle <= 1'b0;
      rdata_out <= 8'h00;
      rdata_valid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      rd_pend <= rd;
      rd_bank <= bank;
      rd_low <= addr_in[1:0];
      rd_sec <= cur_sec;
      rdata_valid_out <= rd_pend;
      if (rd_pend)
      begin
        if (busy && rd_bank == op_bank)
        begin
          rdata_out <= status;
          toggle <= ~toggle;
        end
        else if (state == S_PROT && rd_low == `FCSS_PROT_ADDR)
          rdata_out <= {7'h00, (rd_bank ? prot_all[rd_sec] : prot_primary_in[rd_sec])};
        else
          rdata_out <= rd_bank ? s_rdata : p_rdata;
      end
    end
  end

  // Pin is low while an embedded operation or error holds the array
  assign ready_busy_pin_out = ~busy;
  assign bypass_mode_out = in_byp;
  assign error_flag_bit_out = err_flag;

endmodule // fcss_sequencer

/* File: rtl/fcss_timer.v */
// Loadable down counter for the sequencer's timed windows
`timescale 1ns/1ps
`include "fcss_defines.vh"
module fcss_timer (
  // Clock, reset, enable
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  // Control
  input wire load_in,
  input wire [`FCSS_TMR_W-1:0] count_in,
  // Status
  output wire done_out
);

  reg [`FCSS_TMR_W-1:0] cnt;

  always @(posedge clk_in)
  begin
    if (!rst_n_in)
      cnt <= {`FCSS_TMR_W{1'b0}};
    else if (ce_in)
    begin
      if (load_in)
        cnt <= count_in;
      else if (cnt != {`FCSS_TMR_W{1'b0}})
        cnt <= cnt - {{(`FCSS_TMR_W-1){1'b0}}, 1'b1};
    end
  end

  assign done_out = (cnt == {`FCSS_TMR_W{1'b0}});

endmodule // fcss_timer

/* File: verification/fcss_core_model.sv */
// Behavioural core issuing byte reads and writes to the sequencer
`timescale 1ns/1ps
`include "fcss_defines.vh"
module fcss_core_model (
  // Clock and answer
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rdata_valid_in,
  // Requests
  output logic rd_strobe_out,
  output logic wr_strobe_out,
  output logic [15:0] addr_out,
  output logic [7:0] wdata_out,
  output logic [7:0] primary_sector_selects_out,
  output logic [3:0] secondary_sector_selects_out
);
  initial
  begin
    rd_strobe_out = 1'b0;
    wr_strobe_out = 1'b0;
    addr_out = 16'h0000;
    wdata_out = 8'h00;
    primary_sector_selects_out = 8'h00;
    secondary_sector_selects_out = 4'h0;
  end
  // Sector index 0..7 is primary, 8..11 secondary
  task automatic xfer(input logic r, input int s, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    rd_strobe_out = r;
    wr_strobe_out = !r;
    addr_out = a;
    wdata_out = d;
    primary_sector_selects_out = (s < 8) ? 8'h01 << s : 8'h00;
    secondary_sector_selects_out = (s < 8) ? 4'h0 : 4'h1 << (s - 8);
    @(negedge clk_in);
    rd_strobe_out = 1'b0;
    wr_strobe_out = 1'b0;
    primary_sector_selects_out = 8'h00;
    secondary_sector_selects_out = 4'h0;
    // Released lines show garbage so stale values cannot pass
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
  endtask
  task automatic wr(input int s, input logic [15:0] a, input logic [7:0] d);
    xfer(1'b0, s, a, d);
  endtask
  task automatic rd(input int s, input logic [15:0] a, output logic [7:0] d);
    int n;
    xfer(1'b1, s, a, 8'h00);
    n = 0;
    while (rdata_valid_in !== 1'b1 && n < 4)
    begin
      @(negedge clk_in);
      n++;
    end
    d = (rdata_valid_in === 1'b1) ? rdata_in : 8'hxx;
  endtask
  task automatic unlock(input int s, input logic [3:0] hi);
    wr(s, {hi, `FCSS_ADDR1}, `FCSS_UNLK1);
    wr(s, {hi, `FCSS_ADDR2}, `FCSS_UNLK2);
  endtask
  task automatic wait_done(input int s, input logic [15:0] a);
    logic [7:0] p;
    logic [7:0] q;
    int n;
    rd(s, a, q);
    p = ~q;
    n = 0;
    while (p !== q && n < 1000)
    begin
      p = q;
      rd(s, a, q);
      n++;
    end
  endtask
endmodule // fcss_core_model

/* File: verification/fcss_seq_asserts.sv */
// Port-level assertions for the flash command and status sequencer
`timescale 1ns/1ps
`include "fcss_defines.vh"
module fcss_seq_asserts (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Core bus
  input wire logic rd_strobe_in,
  input wire logic wr_strobe_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic rdata_valid_out,
  // Sector selects
  input wire logic [7:0] primary_sector_selects_in,
  input wire logic [3:0] secondary_sector_selects_in,
  // Status pins
  input wire logic ready_busy_pin_out,
  input wire logic bypass_mode_out,
  input wire logic error_flag_bit_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire sel = (|primary_sector_selects_in) || (|secondary_sector_selects_in);
  wire wr_ok = wr_strobe_in && ce_in && sel;
  property p_rd_lat;
    rd_strobe_in && ce_in && sel |-> ##2 rdata_valid_out;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_src;
    rdata_valid_out |-> $past(rd_strobe_in, 2);
  endproperty
  a_rd_src: assert property (p_rd_src) else $error("answer without read");
  property p_rd_hold;
    !rdata_valid_out |-> $stable(rdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_busy_src;
    $fell(ready_busy_pin_out) |-> $past(wr_ok);
  endproperty
  a_busy_src: assert property (p_busy_src) else $error("busy without write");
  property p_err_busy;
    error_flag_bit_out |-> !ready_busy_pin_out;
  endproperty
  a_err_busy: assert property (p_err_busy) else $error("error while ready");
  property p_err_clr;
    $fell(error_flag_bit_out) && $past(rst_n_in) |-> $past(wr_ok && wdata_in == `FCSS_RESET);
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error cleared without reset command");
  property p_byp_in;
    $rose(bypass_mode_out) |-> $past(wr_ok && wdata_in == `FCSS_BYPASS && addr_in[11:0] == `FCSS_ADDR1);
  endproperty
  a_byp_in: assert property (p_byp_in) else $error("fast mode entered wrongly");
  property p_byp_out;
    $fell(bypass_mode_out) && $past(rst_n_in) |->
      $past(wr_ok && (wdata_in == `FCSS_BYEXIT || wdata_in == `FCSS_RESET));
  endproperty
  a_byp_out: assert property (p_byp_out) else $error("fast mode left wrongly");
endmodule // fcss_seq_asserts

bind fcss_sequencer fcss_seq_asserts u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .rd_strobe_in(rd_strobe_in),
  .wr_strobe_in(wr_strobe_in), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
  .rdata_valid_out(rdata_valid_out), .primary_sector_selects_in(primary_sector_selects_in),
  .secondary_sector_selects_in(secondary_sector_selects_in), .ready_busy_pin_out(ready_busy_pin_out),
  .bypass_mode_out(bypass_mode_out), .error_flag_bit_out(error_flag_bit_out)
);

/* File: verification/tb.sv */
// Self-checking bench for the flash command and status sequencer
`timescale 1ns/1ps
`include "fcss_defines.vh"
module tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] prot_p = 8'h00;
  logic [3:0] prot_s = 4'h0;
  logic rd_s, wr_s, rv, rb, byp, err;
  logic [15:0] addr;
  logic [7:0] wd, rdat, ps, st, s1, s2;
  logic [3:0] ss;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  always #20 clk_in = ~clk_in;
  fcss_sequencer u_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .rd_strobe_in(rd_s), .wr_strobe_in(wr_s),
    .addr_in(addr), .wdata_in(wd), .rdata_out(rdat), .rdata_valid_out(rv),
    .primary_sector_selects_in(ps), .secondary_sector_selects_in(ss), .prot_primary_in(prot_p),
    .prot_secondary_in(prot_s), .ready_busy_pin_out(rb), .bypass_mode_out(byp), .error_flag_bit_out(err)
  );
  fcss_core_model u_core (
    .clk_in(clk_in), .rdata_in(rdat), .rdata_valid_in(rv), .rd_strobe_out(rd_s), .wr_strobe_out(wr_s),
    .addr_out(addr), .wdata_out(wd), .primary_sector_selects_out(ps), .secondary_sector_selects_out(ss)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    total_checks++;
    if ((got & m) !== (exp & m))
    begin
      miscompares++;
      $display("ERROR %0t: byte %h expected %h under mask %h", $time, got, exp, m);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset;
    @(negedge clk_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk(rdat, 8'h00, 8'hff);
    chk1(rb, 1'b1);
    chk1(byp, 1'b0);
    chk1(err, 1'b0);
  endtask
  // Selector 1 waits on the ready pin, 0 on the error flag
  task automatic wait_on(input logic on_ready, input logic v, input int lim);
    n = 0;
    while ((on_ready ? rb : err) !== v && n < lim)
    begin
      @(negedge clk_in);
      n++;
    end
  endtask
  task automatic prog(input int s, input logic [15:0] a, input logic [7:0] d);
    u_core.unlock(s, 4'h0);
    u_core.wr(s, 16'h0555, `FCSS_PROG);
    u_core.wr(s, a, d);
  endtask
  task automatic era(input int s, input logic [7:0] d);
    u_core.unlock(s, 4'h0);
    u_core.wr(s, 16'h0555, `FCSS_ERASE);
    u_core.unlock(s, 4'h0);
    u_core.wr(s, 16'h0555, d);
  endtask
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  initial
  begin
    do_reset();
    prog(8, 16'h0045, 8'h00);
    u_core.wait_done(8, 16'h0045);
    u_core.unlock(0, 4'hf);
    u_core.wr(0, 16'hf555, `FCSS_PROG);
    u_core.wr(0, 16'h0123, 8'h00);
    u_core.rd(0, 16'h0123, s1);
    u_core.rd(8, 16'h0045, st);
    chk(st, 8'h00, 8'hff);
    u_core.rd(0, 16'h0123, s2);
    chk(s1, 8'h80, 8'ha0);
    chk(s1 ^ s2, 8'h40, 8'h40);
    chk1(rb, 1'b0);
    u_core.wait_done(0, 16'h0123);
    u_core.rd(0, 16'h0123, st);
    chk(st, 8'h00, 8'hff);
    chk1(rb, 1'b1);
    prog(0, 16'h0123, 8'h01);
    wait_on(1'b0, 1'b1, 300);
    chk1(err, 1'b1);
    u_core.rd(0, 16'h0123, st);
    chk(st, 8'ha0, 8'ha0);
    u_core.wr(0, 16'h0000, `FCSS_RESET);
    wait_on(1'b0, 1'b0, 700);
    chk1(err, 1'b0);
    chk1(rb, 1'b1);
    prog(1, 16'h0200, 8'h00);
    u_core.wait_done(1, 16'h0200);
    prot_p = 8'h02;
    prog(1, 16'h0200, 8'h01);
    @(negedge clk_in);
    chk1(rb, 1'b1);
    chk1(err, 1'b0);
    u_core.unlock(1, 4'h0);
    u_core.wr(1, 16'h0555, `FCSS_PROTRD);
    u_core.rd(1, 16'h0002, st);
    chk(st, 8'h01, 8'hff);
    u_core.wr(1, 16'h0000, `FCSS_RESET);
    u_core.wr(2, 16'h0555, `FCSS_UNLK1);
    u_core.wr(2, 16'h0aaa, 8'h56);
    u_core.wr(2, 16'h0555, `FCSS_PROG);
    u_core.wr(2, 16'h0300, 8'h00);
    @(negedge clk_in);
    chk1(rb, 1'b1);
    u_core.unlock(2, 4'h0);
    u_core.wr(2, 16'h0555, `FCSS_BYPASS);
    @(negedge clk_in);
    chk1(byp, 1'b1);
    u_core.wr(2, 16'h0000, `FCSS_PROG);
    u_core.wr(2, 16'h0310, 8'h00);
    u_core.wait_done(2, 16'h0310);
    u_core.rd(2, 16'h0310, st);
    chk(st, 8'h00, 8'hff);
    u_core.unlock(2, 4'h0);
    @(negedge clk_in);
    chk1(byp, 1'b1);
    u_core.wr(2, 16'h1234, `FCSS_PROTRD);
    u_core.wr(2, 16'h0042, `FCSS_BYEXIT);
    @(negedge clk_in);
    chk1(byp, 1'b0);
    era(3, `FCSS_SECER);
    u_core.rd(3, 16'h0000, st);
    chk(st, 8'h00, 8'ha8);
    repeat (2940) @(negedge clk_in);
    u_core.rd(3, 16'h0000, st);
    chk(st, 8'h00, 8'h08);
    repeat (80) @(negedge clk_in);
    u_core.rd(3, 16'h0000, st);
    chk(st, 8'h08, 8'h08);
    u_core.wr(3, 16'h0000, `FCSS_RESET);
    wait_on(1'b1, 1'b1, 700);
    chk1(rb, 1'b1);
    era(3, `FCSS_SECER);
    u_core.wr(4, 16'h0000, `FCSS_SECER);
    u_core.rd(4, 16'h0000, st);
    chk(st, 8'h08, 8'h08);
    u_core.wr(3, 16'h0000, `FCSS_RESET);
    wait_on(1'b1, 1'b1, 700);
    prot_s = 4'hf;
    era(8, `FCSS_BULK);
    u_core.rd(8, 16'h0045, s1);
    u_core.rd(8, 16'h0045, s2);
    chk(s1 | s2, 8'h00, 8'hc0);
    wait_on(1'b1, 1'b1, 3000);
    chk1(n >= 2400 && rb === 1'b1, 1'b1);
    u_core.rd(8, 16'h0045, st);
    chk(st, 8'h00, 8'hff);
    u_core.unlock(0, 4'h0);
    u_core.wr(0, 16'h0555, `FCSS_BYPASS);
    do_reset();
    end_of_test();
  end
endmodule // tb
